// ---- rtl/aos_pkg.sv ----
// Constants, codes and state type shared by the analog output sequencer
package aos_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  // Fastest pacing, 500 kS/s
  localparam int PACE_MIN_PERIOD_NS = 2000;
  // Slowest pacing, 0.75 S/s
  localparam int PACE_MAX_PERIOD_NS = 1333333333;
  localparam int PACE_MIN_CYC =
    (PACE_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PACE_MAX_CYC = PACE_MAX_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PACE_W = 24;

  // ****************************************
  // Data words and list
  // ****************************************
  localparam int SAMPLE_W = 16;
  localparam int LAST_BIT = 16;
  localparam int WORD_W = 17;
  localparam int N_ENTRY = 5;
  localparam int FIFO_DEPTH = 32;
  // Offset binary: midscale is 0 V
  localparam logic [15:0] AO_RESET_CODE = 16'h8000;
  localparam logic [15:0] DO_RESET_CODE = 16'h0000;

  // ****************************************
  // Trigger select codes
  // ****************************************
  localparam logic [1:0] TRIG_SW = 2'h0;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_FALL = 2'h2;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ARMED = 5'h02,
    ST_RUN = 5'h04,
    ST_LOAD = 5'h08,
    ST_SHOW = 5'h10
  } aos_state_e;

endpackage

// ---- rtl/aos_sequencer.sv ----
// Output sample FIFO with replay, and the analog output sequencer top
`timescale 1ns/100ps

// ****************************************
// How it works
// ****************************************

// ****************************************
// FIFO
// ****************************************
module aos_fifo #(
  parameter int WIDTH = aos_pkg::WORD_W,
  parameter int DEPTH = aos_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Fill side
  input wire logic [WIDTH-1:0] s_data,
  input wire logic s_valid,
  output logic s_ready,
  // Drain side
  output logic [WIDTH-1:0] m_data,
  output logic m_valid,
  input wire logic m_ready,
  // Replay control
  input wire logic keep,
  input wire logic rewind
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr, rd, base;
  wire push = s_valid && s_ready;
  wire pop = m_valid && m_ready;
  // Kept words are not freed, so a replayed buffer cannot be overwritten
  wire [AW:0] next_rd = rewind ? base : rd + (AW+1)'(pop);
  wire [AW:0] next_base = keep ? base : next_rd;
  wire [AW:0] next_wr = wr + (AW+1)'(push);
  wire [AW:0] next_used = next_wr - next_base;
  assign m_valid = (wr != rd);
  assign m_data = mem[rd[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr[AW-1:0]] <= s_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr <= '0;
      rd <= '0;
      base <= '0;
      s_ready <= 1'b0;
    end else begin
      wr <= next_wr;
      rd <= next_rd;
      base <= next_base;
      s_ready <= (next_used < (AW+1)'(DEPTH));
    end
  end
endmodule

// ****************************************
// Sequencer top
// ****************************************
module aos_sequencer #(
  parameter int N_ENTRY = aos_pkg::N_ENTRY,
  parameter int DEPTH = aos_pkg::FIFO_DEPTH,
  parameter int PACE_W = aos_pkg::PACE_W,
  parameter int PACE_MAX = aos_pkg::PACE_MAX_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Host sample stream
  input wire logic [15:0] in_data,
  input wire logic in_last,
  input wire logic in_valid,
  output logic in_ready,
  // Single-value write
  input wire logic sv_write,
  input wire logic [2:0] sv_chan,
  input wire logic [15:0] sv_data,
  // Continuous configuration
  input wire logic [N_ENTRY-1:0] chan_list,
  input wire logic repeat_one_buffer,
  input wire logic clk_ext_sel,
  input wire logic [1:0] trig_sel,
  input wire logic [PACE_W-1:0] pace_div,
  // Commands
  input wire logic start_cont,
  input wire logic stop_orderly,
  input wire logic stop_abrupt,
  // Pins
  input wire logic trig_pin,
  input wire logic pclk_pin,
  // Outputs and events
  output logic [N_ENTRY-1:0][15:0] chan_out,
  output logic busy,
  output logic armed,
  output logic buffer_done,
  output logic underrun
);
  localparam int CW = $clog2(N_ENTRY + 1);
  localparam int LW = $clog2(DEPTH) + 1;
  localparam logic [PACE_W-1:0] PACE_LO = PACE_W'(aos_pkg::PACE_MIN_CYC);
  localparam logic [PACE_W-1:0] PACE_HI = PACE_W'(PACE_MAX);

  aos_pkg::aos_state_e st, next_st;
  logic [2:0] t_sync, p_sync;
  logic [PACE_W-1:0] pace_cnt;
  logic [CW-1:0] cur;
  logic [N_ENTRY-1:0][15:0] shadow;
  logic after_last, grp_any, stop_pend, finish;
  logic [1:0] stop_left;
  logic [LW-1:0] lasts;
  logic [aos_pkg::WORD_W-1:0] f_data;
  logic f_valid;

  // Pin edges; first sync stage feeds only the second
  wire trig_rise = t_sync[1] && !t_sync[2];
  wire trig_fall = !t_sync[1] && t_sync[2];
  wire pclk_rise = p_sync[1] && !p_sync[2];
  wire ext_hit = (trig_sel == aos_pkg::TRIG_RISE) ? trig_rise :
                 (trig_sel == aos_pkg::TRIG_FALL) ? trig_fall : 1'b0;
  wire sw_trig = (trig_sel == aos_pkg::TRIG_SW);
  wire go = (st == aos_pkg::ST_ARMED) && (sw_trig || ext_hit);
  wire [PACE_W-1:0] pace_eff = (pace_div < PACE_LO) ? PACE_LO :
                               (pace_div > PACE_HI) ? PACE_HI : pace_div;
  wire running = (st == aos_pkg::ST_RUN) || (st == aos_pkg::ST_LOAD) ||
                 (st == aos_pkg::ST_SHOW);
  // One shared tick for all entries
  wire tick = (st == aos_pkg::ST_RUN) &&
              (clk_ext_sel ? pclk_rise : (pace_cnt == '0));
  wire cur_end = (cur == CW'(N_ENTRY));
  wire entry_on = !cur_end && chan_list[cur];
  wire loading = (st == aos_pkg::ST_LOAD);
  wire pop = loading && entry_on && f_valid;
  wire starve = loading && entry_on && !f_valid;
  wire clean_end = starve && !grp_any && after_last;
  // Underrun ends the run, outputs hold
  wire under = starve && !clean_end;
  wire pop_last = pop && f_data[aos_pkg::LAST_BIT];
  wire rewind = pop_last && repeat_one_buffer;
  wire push_last = in_valid && in_ready && in_last;
  wire lasts_dec = pop_last && !repeat_one_buffer;
  wire [LW-1:0] next_lasts = lasts + LW'(push_last) - LW'(lasts_dec);
  wire [1:0] stop_count = (lasts >= LW'(2) && !repeat_one_buffer) ?
                          2'h2 : 2'h1;
  wire stop_now = stop_pend && (stop_left == 2'h1) && pop_last;

  aos_fifo #(.WIDTH(aos_pkg::WORD_W), .DEPTH(DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .s_data({in_last, in_data}),
    .s_valid(in_valid),
    .s_ready(in_ready),
    .m_data(f_data),
    .m_valid(f_valid),
    .m_ready(pop),
    .keep(repeat_one_buffer),
    .rewind(rewind)
  );

  always_comb begin
    next_st = st;
    case (st)
      aos_pkg::ST_IDLE: begin
        if (start_cont) begin
          next_st = aos_pkg::ST_ARMED;
        end
      end
      aos_pkg::ST_ARMED: begin
        if (stop_orderly) begin
          next_st = aos_pkg::ST_IDLE;
        end else if (go) begin
          next_st = aos_pkg::ST_RUN;
        end
      end
      aos_pkg::ST_RUN: begin
        if (tick) begin
          next_st = aos_pkg::ST_LOAD;
        end
      end
      aos_pkg::ST_LOAD: begin
        if (under || clean_end) begin
          next_st = aos_pkg::ST_IDLE;
        end else if (cur_end) begin
          next_st = aos_pkg::ST_SHOW;
        end
      end
      aos_pkg::ST_SHOW: begin
        next_st = finish ? aos_pkg::ST_IDLE : aos_pkg::ST_RUN;
      end
      default: next_st = aos_pkg::ST_IDLE;
    endcase
    if (stop_abrupt) begin
      next_st = aos_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= aos_pkg::ST_IDLE;
      t_sync <= 3'h0;
      p_sync <= 3'h0;
    end else begin
      st <= next_st;
      t_sync <= {t_sync[1:0], trig_pin};
      p_sync <= {p_sync[1:0], pclk_pin};
    end
  end

  // Internal pacing divider, runs through load and show
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !running || pace_cnt == '0) begin
      pace_cnt <= pace_eff - PACE_W'(1);
    end else begin
      pace_cnt <= pace_cnt - PACE_W'(1);
    end
  end

  // One word per listed entry each tick
  always_ff @(posedge clk_sys) begin
    if (sys_rst || st != aos_pkg::ST_LOAD) begin
      cur <= '0;
      grp_any <= 1'b0;
    end else if (!cur_end && (!entry_on || f_valid)) begin
      cur <= cur + CW'(1);
      grp_any <= grp_any || pop;
    end
  end

  // Small buffers: stop after current and next
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stop_pend <= 1'b0;
      stop_left <= 2'h0;
      finish <= 1'b0;
      after_last <= 1'b1;
      lasts <= '0;
    end else begin
      lasts <= next_lasts;
      if (st == aos_pkg::ST_IDLE) begin
        stop_pend <= 1'b0;
        finish <= 1'b0;
        after_last <= 1'b1;
      end else begin
        if (pop) begin
          after_last <= f_data[aos_pkg::LAST_BIT];
        end
        if (stop_orderly && running && !stop_pend) begin
          stop_pend <= 1'b1;
          stop_left <= stop_count;
        end else if (stop_pend && pop_last && stop_left != 2'h1) begin
          stop_left <= stop_left - 2'h1;
        end
        if (stop_now) begin
          finish <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      buffer_done <= 1'b0;
      underrun <= 1'b0;
      busy <= 1'b0;
      armed <= 1'b0;
    end else begin
      buffer_done <= push_last;
      underrun <= under && !stop_abrupt;
      busy <= (next_st != aos_pkg::ST_IDLE);
      armed <= (next_st == aos_pkg::ST_ARMED);
    end
  end

  // Entry N_ENTRY-1 is the digital port
  for (genvar g = 0; g < N_ENTRY; g++) begin : g_entry
    localparam logic [15:0] RST_CODE = (g == N_ENTRY - 1) ?
      aos_pkg::DO_RESET_CODE : aos_pkg::AO_RESET_CODE;
    wire sv_hit = sv_write && (sv_chan == 3'(g));
    wire show_hit = (st == aos_pkg::ST_SHOW) && chan_list[g];
    always_ff @(posedge clk_sys) begin
      if (pop && cur == CW'(g)) begin
        shadow[g] <= f_data[aos_pkg::SAMPLE_W-1:0];
      end
    end
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        chan_out[g] <= RST_CODE;
      end else if (sv_hit) begin
        chan_out[g] <= sv_data;
      end else if (show_hit) begin
        chan_out[g] <= shadow[g];
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_sv_update: assert property (sv_write && sv_chan < 3'(N_ENTRY) |=>
    chan_out[$past(sv_chan)] == $past(sv_data))
    else $error("single value not applied");
  a_out_stable: assert property (!sv_write && st != aos_pkg::ST_SHOW
    |=> $stable(chan_out))
    else $error("outputs moved outside an update");
  a_abort_halts: assert property (stop_abrupt |=> !busy)
    else $error("abrupt stop did not halt");
  a_idle_ignores: assert property (st == aos_pkg::ST_IDLE
    && !start_cont |=> st == aos_pkg::ST_IDLE)
    else $error("idle left without start");
  a_under_halts: assert property (underrun |-> !busy)
    else $error("still running after underrun");
  a_under_cause: assert property (starve && !clean_end && !stop_abrupt
    |=> underrun)
    else $error("missing underrun pulse");
  a_buf_done: assert property (push_last |=> buffer_done)
    else $error("buffer done missing");
  a_tick_load: assert property (tick && !stop_abrupt
    |=> st == aos_pkg::ST_LOAD ##[1:8] st != aos_pkg::ST_LOAD)
    else $error("load not bounded after tick");
  a_pace_min: assert property (tick && !clk_ext_sel |=> !tick[*8])
    else $error("internal ticks too close");
  a_wrap_keeps: assert property (rewind |=> f_valid)
    else $error("wrapped buffer lost");
  a_stop_ends: assert property (stop_now && !stop_abrupt
    |-> ##[1:8] st == aos_pkg::ST_IDLE)
    else $error("orderly stop did not end");

  c_underrun: cover property (underrun);
  c_wrap: cover property (rewind ##[1:100] st == aos_pkg::ST_SHOW);
  c_orderly: cover property (stop_now ##[1:8] !busy);
  c_stream_end: cover property (clean_end);
endmodule

// ---- bench/aos_host_model.sv ----
// Host-side model that feeds sample words to the sequencer
`timescale 1ns/100ps
module aos_host_model (
  // Clock
  input wire logic clk_sys,
  // Sample stream
  output logic [15:0] in_data,
  output logic in_last,
  output logic in_valid,
  input wire logic in_ready
);
  initial begin
    in_data = 16'h0000;
    in_last = 1'b0;
    in_valid = 1'b0;
  end
  // ****
  // Transfers
  // ****
  // Caller orders words
  task automatic send(input logic [15:0] w, input logic l);
    int n;
    in_data <= w;
    in_last <= l;
    in_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (in_ready !== 1'b1 && n < 400);
  endtask
  // Released bus shows a stale-inverse word
  task automatic idle;
    in_valid <= 1'b0;
    in_last <= 1'b0;
    in_data <= ~in_data;
  endtask
endmodule

// ---- bench/aos_sequencer_tb.sv ----
// Self-checking bench for the analog output sequencer
`timescale 1ns/100ps
module aos_sequencer_tb;
  logic clk_sys, sys_rst, in_last, in_valid, in_ready, sv_write;
  logic [15:0] in_data, sv_data;
  logic [2:0] sv_chan;
  logic [4:0] chan_list;
  logic repeat_one_buffer, clk_ext_sel, start_cont, stop_orderly;
  logic [1:0] trig_sel;
  logic [23:0] pace_div;
  logic stop_abrupt, trig_pin, busy, armed, buffer_done;
  logic pclk_pin = 1'b0;
  logic underrun, pclk_en;
  logic [4:0][15:0] chan_out;
  int fails = 0, checked = 0, bd = 0, ur = 0, pcnt = 0;

  // Short pacing bound keeps the run brief
  aos_sequencer #(.PACE_MAX(200)) dut_u (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .in_data(in_data), .in_last(in_last),
    .in_valid(in_valid), .in_ready(in_ready), .sv_write(sv_write),
    .sv_chan(sv_chan), .sv_data(sv_data), .chan_list(chan_list),
    .repeat_one_buffer(repeat_one_buffer), .clk_ext_sel(clk_ext_sel),
    .trig_sel(trig_sel), .pace_div(pace_div), .start_cont(start_cont),
    .stop_orderly(stop_orderly), .stop_abrupt(stop_abrupt),
    .trig_pin(trig_pin), .pclk_pin(pclk_pin), .chan_out(chan_out),
    .busy(busy), .armed(armed), .buffer_done(buffer_done),
    .underrun(underrun));
  aos_host_model host_u (.clk_sys(clk_sys), .in_data(in_data),
    .in_last(in_last), .in_valid(in_valid), .in_ready(in_ready));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Event counts and a slow external pacing clock
  always @(posedge clk_sys) begin
    if (buffer_done === 1'b1) bd <= bd + 1;
    if (underrun === 1'b1) ur <= ur + 1;
    pcnt <= (pcnt == 9) ? 0 : pcnt + 1;
    if (pcnt == 9) pclk_pin <= ~pclk_pin & pclk_en;
  end
  // ****
  // Helpers
  // ****
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_chg(input int lim);
    logic [4:0][15:0] snap;
    int n;
    snap = chan_out;
    n = 0;
    while (chan_out === snap && n < lim) begin
      tick(1);
      n++;
    end
    check(16'(n < lim), 16'h0001);
  endtask
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < lim) begin
      tick(1);
      n++;
    end
    check(16'(n < lim), 16'h0001);
  endtask
  task automatic do_reset;
    sys_rst <= 1'b1;
    trig_pin <= 1'b0;
    pclk_en <= 1'b0;
    tick(10);
    sys_rst <= 1'b0;
    tick(2);
  endtask
  task automatic cfg(input logic [4:0] l, input logic w, e,
    input logic [1:0] t);
    chan_list <= l;
    repeat_one_buffer <= w;
    clk_ext_sel <= e;
    trig_sel <= t;
  endtask
  task automatic start;
    start_cont <= 1'b1;
    tick(1);
    start_cont <= 1'b0;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_single;
    logic [15:0] v;
    for (int i = 0; i < 4; i++) check(chan_out[i], 16'h8000);
    check(chan_out[4], 16'h0000);
    for (int i = 0; i < 5; i++) begin
      // Entry 4 needs a value unlike its reset code
      v = (i == 4) ? 16'hA5A5 : (i % 2) ? 16'hFFFF : 16'h0000;
      sv_write <= 1'b1;
      sv_chan <= 3'(i);
      sv_data <= v;
      tick(1);
      sv_write <= 1'b0;
      tick(1);
      check(chan_out[i], v);
    end
    check(16'(busy), 16'h0000);
  endtask
  task automatic t_stream;
    cfg(5'h11, 1'b0, 1'b0, aos_pkg::TRIG_SW);
    for (int g = 0; g < 16; g++) begin
      host_u.send(16'h1000 + 16'(g), 1'b0);
      host_u.send(16'h4000 + 16'(g), g % 4 == 3);
    end
    host_u.idle;
    tick(2);
    check(16'(in_ready), 16'h0000);
    check(16'(bd), 16'h0004);
    start;
    tick(1);
    check(16'(armed), 16'h0001);
    for (int g = 0; g < 16; g++) begin
      wait_chg(100);
      check(chan_out[0], 16'h1000 + 16'(g));
      check(chan_out[4], 16'h4000 + 16'(g));
    end
    wait_idle(100);
    check(16'(ur), 16'h0000);
  endtask
  task automatic t_underrun;
    cfg(5'h04, 1'b0, 1'b0, aos_pkg::TRIG_SW);
    host_u.send(16'h2222, 1'b0);
    host_u.idle;
    start;
    wait_chg(100);
    check(chan_out[2], 16'h2222);
    wait_idle(100);
    tick(2);
    check(16'(ur), 16'h0001);
    check(chan_out[2], 16'h2222);
  endtask
  task automatic t_wrap;
    logic [15:0] w [3];
    int b0;
    w = '{16'h0000, 16'hFFFF, 16'h7FFF};
    b0 = bd;
    cfg(5'h02, 1'b1, 1'b1, aos_pkg::TRIG_FALL);
    trig_pin <= 1'b1;
    pclk_en <= 1'b1;
    for (int i = 0; i < 3; i++) host_u.send(w[i], i == 2);
    host_u.idle;
    start;
    tick(10);
    check(16'(armed), 16'h0001);
    trig_pin <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      wait_chg(100);
      check(chan_out[1], w[i % 3]);
    end
    check(16'(bd - b0), 16'h0001);
    stop_abrupt <= 1'b1;
    tick(1);
    stop_abrupt <= 1'b0;
    tick(1);
    check(16'(busy), 16'h0000);
    trig_pin <= 1'b1;
    tick(4);
    trig_pin <= 1'b0;
    tick(60);
    check(chan_out[1], w[0]);
  endtask
  task automatic t_orderly;
    cfg(5'h01, 1'b0, 1'b0, aos_pkg::TRIG_RISE);
    for (int i = 1; i < 7; i++) host_u.send(16'h0100 + 16'(i), i % 2 == 0);
    host_u.idle;
    start;
    tick(5);
    trig_pin <= 1'b1;
    wait_chg(100);
    check(chan_out[0], 16'h0101);
    stop_orderly <= 1'b1;
    tick(1);
    stop_orderly <= 1'b0;
    for (int i = 2; i < 5; i++) begin
      wait_chg(100);
      check(chan_out[0], 16'h0100 + 16'(i));
    end
    wait_idle(100);
    trig_pin <= 1'b0;
    tick(4);
    trig_pin <= 1'b1;
    tick(80);
    check(chan_out[0], 16'h0104);
    check(16'(busy), 16'h0000);
  endtask
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog, far beyond the thousand or so cycles needed
  initial begin
    tick(20000);
    fails++;
    $display("ERROR %0t watchdog expired", $time);
    final_report;
  end
  initial begin
    sys_rst = 1'b1;
    sv_write = 1'b0;
    sv_chan = 3'h0;
    sv_data = 16'h0000;
    chan_list = 5'h00;
    repeat_one_buffer = 1'b0;
    clk_ext_sel = 1'b0;
    trig_sel = 2'h0;
    pace_div = 24'h000014;
    start_cont = 1'b0;
    stop_orderly = 1'b0;
    stop_abrupt = 1'b0;
    trig_pin = 1'b0;
    pclk_en = 1'b0;
    do_reset;
    t_single;
    do_reset;
    t_stream;
    do_reset;
    t_underrun;
    do_reset;
    t_wrap;
    do_reset;
    t_orderly;
    final_report;
  end
endmodule
